// >>> inc/fpd_pkg.sv
// package: constants, types and helpers of the rc postscaler and pll divider control
package fpd_pkg;

  // register port geometry and offsets
  localparam int          ADDR_W       = 2;
  localparam int          DATA_W       = 16;
  localparam logic [1:0]  OFS_CLOCK_DIVISOR = 2'h0;
  localparam logic [1:0]  OFS_PLL_FEEDBACK  = 2'h1;
  localparam logic [1:0]  OFS_OSC_CONTROL   = 2'h2;

  // clock_divisor field positions
  localparam int          POS_IN_DIV   = 0;   // loop_input_divider, 5 bits
  localparam int          POS_OUT_DIV  = 6;   // loop_output_divider, 2 bits
  localparam int          POS_RC_POST  = 8;   // rc_post_divide_sel, 3 bits
  // pll_feedback_divisor field position
  localparam int          POS_FB       = 0;   // loop_feedback_value, 9 bits
  // oscillator_control field positions
  localparam int          POS_SW_REQ   = 0;
  localparam int          POS_LOCK     = 5;
  localparam int          POS_NEW_SRC  = 8;
  localparam int          POS_CUR_SRC  = 12;

  // reset values
  localparam logic [4:0]  RST_IN_DIV   = 5'h00;
  localparam logic [1:0]  RST_OUT_DIV  = 2'h1;
  localparam logic [8:0]  RST_FB       = 9'h030;
  localparam logic [2:0]  RST_RC_POST  = 3'h0;

  // ratio arithmetic
  localparam logic [5:0]  IN_DIV_OFFSET  = 6'h02;
  localparam logic [9:0]  FB_OFFSET      = 10'h002;
  localparam logic [3:0]  OUT_DIV_OFFSET = 4'h2;
  localparam logic [2:0]  DIV16_SEL      = 3'h4;
  localparam logic [2:0]  DIV256_SEL     = 3'h7;
  localparam logic [8:0]  DIV256_TOP     = 9'h100;

  // lock interval timing
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          LOCK_TIME_NS   = 1000;
  localparam int          LOCK_CYCLES    = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // clock source codes
  typedef enum logic [2:0] {
    SRC_FAST_RC                     = 3'b000,
    SRC_RC_WITH_MULTIPLIER          = 3'b001,
    SRC_PRIMARY                     = 3'b010,
    SRC_EXT_CLOCK_WITH_MULTIPLIER   = 3'b011,
    SRC_SECONDARY                   = 3'b100,
    SRC_LOW_POWER_RC                = 3'b101,
    SRC_RC_DIVIDE_16                = 3'b110,
    SRC_RC_VARIABLE_DIVIDE          = 3'b111
  } fpd_src_type;

  localparam fpd_src_type RST_SRC = SRC_RC_VARIABLE_DIVIDE;

  // postscaler terminal count for a selection code
  function automatic logic [8:0] fpd_div_top(input logic [2:0] sel);
    fpd_div_top = (sel == DIV256_SEL) ? DIV256_TOP : (9'h001 << sel);
  endfunction

  function automatic logic fpd_uses_pll(input fpd_src_type src);
    fpd_uses_pll = (src == SRC_RC_WITH_MULTIPLIER) || (src == SRC_EXT_CLOCK_WITH_MULTIPLIER);
  endfunction

  function automatic logic [5:0] fpd_n1(input logic [4:0] f);
    fpd_n1 = {1'b0, f} + IN_DIV_OFFSET;
  endfunction

  function automatic logic [9:0] fpd_m(input logic [8:0] f);
    fpd_m = {1'b0, f} + FB_OFFSET;
  endfunction

  function automatic logic [3:0] fpd_n2(input logic [1:0] f);
    fpd_n2 = {1'b0, f, 1'b0} + OUT_DIV_OFFSET;
  endfunction

endpackage

// >>> inc/fpd_div_if.sv
// interface: tick path between the control block and the rc postscaler
`timescale 1ns/10ps
interface fpd_div_if;
  logic       in_tick;
  logic [2:0] sel;
  logic       out_tick;

  modport ctl (output in_tick, output sel, input out_tick);
  modport div (input in_tick, input sel, output out_tick);
endinterface

// >>> src/fpd_postscaler.sv
// module: fast rc postscaler, divides rc ticks by 1 to 256
`timescale 1ns/10ps
module fpd_postscaler (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // tick path
  fpd_div_if.div   dif
);
  import fpd_pkg::*;

  logic [7:0] cnt_reg;
  logic [2:0] act_sel_reg;
  logic       out_tick_reg;
  logic       wrap;

  // last input tick of the current division period
  assign wrap = dif.in_tick && ({1'b0, cnt_reg} == fpd_div_top(act_sel_reg) - 9'h001);

  // count rc ticks, pick up a new selection only at wrap so no short pulse
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_reg      <= 8'h00;
      act_sel_reg  <= RST_RC_POST;
      out_tick_reg <= 1'b0;
    end else begin
      out_tick_reg <= wrap;
      if (wrap) begin
        cnt_reg     <= 8'h00;
        act_sel_reg <= dif.sel;
      end else if (dif.in_tick) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  assign dif.out_tick = out_tick_reg;

  a_div_boundary: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (act_sel_reg != $past(act_sel_reg)) |-> $past(wrap))
    else $error("postscaler selection changed inside a period");

  a_div_period: assert property (@(posedge sys_clk) disable iff (!reset_n)
    out_tick_reg |-> $past(dif.in_tick)
      && ({1'b0, $past(cnt_reg)} == fpd_div_top($past(act_sel_reg)) - 9'h001))
    else $error("postscaler tick not at terminal count");

endmodule // fpd_postscaler

// >>> src/fpd_top.sv
// module: fast rc postscaler and pll divider control with lock status
`timescale 1ns/10ps
//
// Summary of operation
// - rc postscaler codes divide 1,2,4..64,256
// - postscaler select in clock_divisor bits 10:8
// - divided rc clock feeds the pll reference
// - input divider N1 is field plus two
// - feedback divider M is field plus two
// - output divider N2 is twice field plus two
// - system clock is input times M/(N1*N2)
// - reset ratios N1=2, N2=4, M=50
// - lock interval restarts on N1 or M change or switch
// - lock timing starts once reference present
// - lock bit five read-only in oscillator_control
// - lock clear at reset, switch, non-pll source
// - instruction clock is half system clock
// - code 001 rc with pll, 111 variable
// - code 011 primary oscillator with pll
module fpd_top #(
  parameter int LOCK_CNT = fpd_pkg::LOCK_CYCLES
) (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  // register port
  input  wire logic [fpd_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [fpd_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [fpd_pkg::DATA_W-1:0]  reg_rdata,
  // oscillator side
  input  wire logic [2:0]                  initial_source_code,
  input  wire logic                        rc_tick,
  input  wire logic                        prim_tick,
  input  wire logic                        startup_timer_done,
  input  wire logic                        pll_out_tick,
  // pll macro control
  output logic                             pll_ref_tick,
  output logic      [5:0]                  pll_in_ratio,
  output logic      [9:0]                  pll_fb_ratio,
  output logic      [3:0]                  pll_out_ratio,
  // clock status and ticks
  output logic                             pll_locked,
  output logic      [2:0]                  cur_source,
  output logic                             sys_clk_tick,
  output logic                             instr_tick
);
  import fpd_pkg::*;

  localparam int CW = $clog2(LOCK_CNT + 1);
  localparam logic [CW-1:0] LOCK_LAST = CW'(LOCK_CNT - 1);

  // software-visible fields
  logic [4:0]          loop_input_divider_reg;
  logic [1:0]          loop_output_divider_reg;
  logic [2:0]          rc_post_divide_sel_reg;
  logic [8:0]          loop_feedback_value_reg;
  fpd_src_type         new_src_reg;
  logic                sw_req_reg;
  // clock selection and lock state
  fpd_src_type         cur_src_reg;
  logic                boot_reg;
  logic                lock_reg;
  logic [CW-1:0]       lock_cnt_reg;
  // registered outputs
  logic [5:0]          n1_reg;
  logic [9:0]          m_reg;
  logic [3:0]          n2_reg;
  logic                ref_tick_reg;
  logic                sys_tick_reg;
  logic                instr_phase_reg;
  logic                instr_tick_reg;
  logic [DATA_W-1:0]   rdata_reg;
  // decoded strobes and events
  logic                wr_clock_divisor;
  logic                wr_fb;
  logic                wr_osc;
  logic                switch_now;
  logic                relock;
  logic                ref_present;
  logic                sys_tick_next;
  logic [DATA_W-1:0]   rdata_next;

  fpd_div_if dif ();

  // write strobes per register
  assign wr_clock_divisor = reg_wr && (reg_addr == OFS_CLOCK_DIVISOR);
  assign wr_fb     = reg_wr && (reg_addr == OFS_PLL_FEEDBACK);
  assign wr_osc    = reg_wr && (reg_addr == OFS_OSC_CONTROL);

  // clock_divisor and pll_feedback_divisor fields
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      loop_input_divider_reg  <= RST_IN_DIV;
      loop_output_divider_reg <= RST_OUT_DIV;
      rc_post_divide_sel_reg  <= RST_RC_POST;
      loop_feedback_value_reg <= RST_FB;
    end else begin
      if (wr_clock_divisor) begin
        loop_input_divider_reg  <= reg_wdata[POS_IN_DIV +: 5];
        loop_output_divider_reg <= reg_wdata[POS_OUT_DIV +: 2];
        rc_post_divide_sel_reg  <= reg_wdata[POS_RC_POST +: 3];
      end
      if (wr_fb) begin
        loop_feedback_value_reg <= reg_wdata[POS_FB +: 9];
      end
    end
  end

  // requested source and switch request; a new request beats the clear
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      new_src_reg <= RST_SRC;
      sw_req_reg  <= 1'b0;
    end else begin
      if (wr_osc) begin
        new_src_reg <= fpd_src_type'(reg_wdata[POS_NEW_SRC +: 3]);
      end
      if (wr_osc && reg_wdata[POS_SW_REQ]) begin
        sw_req_reg <= 1'b1;
      end else if (sw_req_reg) begin
        sw_req_reg <= 1'b0;
      end
    end
  end

  assign switch_now = sw_req_reg && boot_reg;

  // current source: strap taken on the first edge after reset, then switches
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cur_src_reg <= RST_SRC;
      boot_reg    <= 1'b0;
    end else if (!boot_reg) begin
      cur_src_reg <= fpd_src_type'(initial_source_code);
      boot_reg    <= 1'b1;
    end else if (switch_now) begin
      cur_src_reg <= new_src_reg;
    end
  end

  // events that force a fresh lock interval
  assign relock = !boot_reg
               || (switch_now && fpd_uses_pll(new_src_reg))
               || (wr_clock_divisor && (reg_wdata[POS_IN_DIV +: 5] != loop_input_divider_reg))
               || (wr_fb && (reg_wdata[POS_FB +: 9] != loop_feedback_value_reg));

  // reference counts as present for rc at once, for primary after start-up
  assign ref_present = (cur_src_reg == SRC_EXT_CLOCK_WITH_MULTIPLIER) ?
                       startup_timer_done : 1'b1;

  // lock interval counter and lock status
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lock_reg     <= 1'b0;
      lock_cnt_reg <= '0;
    end else if (!fpd_uses_pll(cur_src_reg) || relock
                 || (switch_now && !fpd_uses_pll(new_src_reg))) begin
      // leaving the pll clears lock in the switch cycle, never one cycle late
      lock_reg     <= 1'b0;
      lock_cnt_reg <= '0;
    end else if (ref_present && !lock_reg) begin
      if (lock_cnt_reg == LOCK_LAST) begin
        lock_reg <= 1'b1;
      end else begin
        lock_cnt_reg <= lock_cnt_reg + CW'(1);
      end
    end
  end

  // postscaler: fixed divide by 16 for that source, else the software code
  assign dif.in_tick = rc_tick;
  assign dif.sel     = (cur_src_reg == SRC_RC_DIVIDE_16) ? DIV16_SEL : rc_post_divide_sel_reg;

  fpd_postscaler u_postscaler (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .dif     (dif)
  );

  // pll reference routing
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ref_tick_reg <= 1'b0;
    end else begin
      unique case (cur_src_reg)
        SRC_RC_WITH_MULTIPLIER:        ref_tick_reg <= dif.out_tick;
        SRC_EXT_CLOCK_WITH_MULTIPLIER: ref_tick_reg <= prim_tick && startup_timer_done;
        default:                       ref_tick_reg <= 1'b0;
      endcase
    end
  end

  // ratios reach the pll only while it is not clocking the system
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      n1_reg <= fpd_n1(RST_IN_DIV);
      m_reg  <= fpd_m(RST_FB);
      n2_reg <= fpd_n2(RST_OUT_DIV);
    end else if (!fpd_uses_pll(cur_src_reg)) begin
      n1_reg <= fpd_n1(loop_input_divider_reg);
      m_reg  <= fpd_m(loop_feedback_value_reg);
      n2_reg <= fpd_n2(loop_output_divider_reg);
    end
  end

  // system clock tick from the selected source
  always_comb begin
    unique case (cur_src_reg)
      SRC_FAST_RC:                   sys_tick_next = rc_tick;
      SRC_RC_DIVIDE_16,
      SRC_RC_VARIABLE_DIVIDE:        sys_tick_next = dif.out_tick;
      SRC_PRIMARY:                   sys_tick_next = prim_tick && startup_timer_done;
      SRC_RC_WITH_MULTIPLIER,
      SRC_EXT_CLOCK_WITH_MULTIPLIER: sys_tick_next = pll_out_tick && lock_reg;
      default:                       sys_tick_next = 1'b0;
    endcase
  end

  // system tick and instruction tick at half its rate
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sys_tick_reg    <= 1'b0;
      instr_phase_reg <= 1'b0;
      instr_tick_reg  <= 1'b0;
    end else begin
      sys_tick_reg   <= sys_tick_next;
      instr_tick_reg <= sys_tick_reg && instr_phase_reg;
      if (sys_tick_reg) begin
        instr_phase_reg <= !instr_phase_reg;
      end
    end
  end

  // read data, lock is read-only and reserved bits read zero
  always_comb begin
    rdata_next = '0;
    unique case (reg_addr)
      OFS_CLOCK_DIVISOR: begin
        rdata_next[POS_IN_DIV +: 5]  = loop_input_divider_reg;
        rdata_next[POS_OUT_DIV +: 2] = loop_output_divider_reg;
        rdata_next[POS_RC_POST +: 3] = rc_post_divide_sel_reg;
      end
      OFS_PLL_FEEDBACK: begin
        rdata_next[POS_FB +: 9] = loop_feedback_value_reg;
      end
      OFS_OSC_CONTROL: begin
        rdata_next[POS_SW_REQ]       = sw_req_reg;
        rdata_next[POS_LOCK]         = lock_reg;
        rdata_next[POS_NEW_SRC +: 3] = new_src_reg;
        rdata_next[POS_CUR_SRC +: 3] = cur_src_reg;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdata_reg <= '0;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  // output drive
  assign reg_rdata     = rdata_reg;
  assign pll_ref_tick  = ref_tick_reg;
  assign pll_in_ratio  = n1_reg;
  assign pll_fb_ratio  = m_reg;
  assign pll_out_ratio = n2_reg;
  assign pll_locked    = lock_reg;
  assign cur_source    = cur_src_reg;
  assign sys_clk_tick  = sys_tick_reg;
  assign instr_tick    = instr_tick_reg;

  a_lock_nonpll: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !fpd_uses_pll(cur_src_reg) |-> !lock_reg)
    else $error("lock set while source does not use the pll");

  a_lock_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(lock_reg) |-> $past(lock_cnt_reg) == LOCK_LAST && $past(ref_present))
    else $error("lock set before the lock interval ran out");

  a_switch_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (switch_now && fpd_uses_pll(new_src_reg)) |=> !lock_reg ##1 !lock_reg)
    else $error("lock not cleared by a switch to a pll source");

  a_reset_ratios: assert property (@(posedge sys_clk)
    !reset_n |=> n1_reg == 6'h02 && n2_reg == 4'h4 && m_reg == 10'h032)
    else $error("pll ratios wrong after reset");

  a_ratio_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (wr_clock_divisor && !fpd_uses_pll(cur_src_reg) && !switch_now) ##1 !fpd_uses_pll(cur_src_reg)
      |=> n1_reg == $past(reg_wdata[POS_IN_DIV +: 5], 2) + 6'h02
       && n2_reg == {$past(reg_wdata[POS_OUT_DIV +: 2], 2), 1'b0} + 4'h2)
    else $error("input or output ratio not tracking clock_divisor");

  a_fb_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (wr_fb && !fpd_uses_pll(cur_src_reg) && !switch_now) ##1 !fpd_uses_pll(cur_src_reg)
      |=> m_reg == $past(reg_wdata[POS_FB +: 9], 2) + 10'h002)
    else $error("feedback ratio not tracking pll_feedback_divisor");

  a_ratio_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fpd_uses_pll($past(cur_src_reg)) |-> $stable(n1_reg) && $stable(m_reg) && $stable(n2_reg))
    else $error("pll ratios changed while the pll clocks the system");

  a_instr_half: assert property (@(posedge sys_clk) disable iff (!reset_n)
    instr_tick_reg |-> $past(sys_tick_reg) && $past(instr_phase_reg))
    else $error("instruction tick not on every second system tick");

  a_lock_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == OFS_OSC_CONTROL) |=> reg_rdata[POS_LOCK] == $past(lock_reg))
    else $error("lock status read back wrong");

  a_ref_route: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cur_src_reg == SRC_RC_WITH_MULTIPLIER && dif.out_tick) |=> pll_ref_tick)
    else $error("divided rc clock not routed to pll reference");

  a_boot_source: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !boot_reg |=> cur_source == $past(initial_source_code))
    else $error("initial source code not applied after reset");

endmodule // fpd_top

// >>> sim/fpd_top_bench.sv
// testbench: register-driven checks of the rc postscaler, pll dividers and lock status
`timescale 1ns/10ps
module fpd_top_bench;
  import fpd_pkg::*;

  localparam int LOCK = 6;  // shortened lock count for simulation

  // clock and reset
  logic        sys_clk;
  logic        reset_n;
  // register port
  logic [1:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  // oscillator side and status
  logic [2:0]  initial_source_code;
  logic        rc_tick;
  logic        prim_tick;
  logic        startup_timer_done;
  logic        pll_out_tick;
  logic        pll_ref_tick;
  logic [5:0]  pll_in_ratio;
  logic [9:0]  pll_fb_ratio;
  logic [3:0]  pll_out_ratio;
  logic        pll_locked;
  logic [2:0]  cur_source;
  logic        sys_clk_tick;
  logic        instr_tick;
  // bench bookkeeping
  int          n_fail;
  int          checked;
  int          cycles;
  logic [15:0] d;
  int          g;
  int          sc;
  int          ic;

  fpd_top #(.LOCK_CNT(LOCK)) i_fpd_top (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .initial_source_code(initial_source_code), .rc_tick(rc_tick), .prim_tick(prim_tick),
    .startup_timer_done(startup_timer_done), .pll_out_tick(pll_out_tick),
    .pll_ref_tick(pll_ref_tick), .pll_in_ratio(pll_in_ratio), .pll_fb_ratio(pll_fb_ratio),
    .pll_out_ratio(pll_out_ratio), .pll_locked(pll_locked), .cur_source(cur_source),
    .sys_clk_tick(sys_clk_tick), .instr_tick(instr_tick)
  );

  // free-running 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, the whole sequence needs well under this
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("MISMATCH timeout expected finish seen hang");
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_write(input logic [1:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read strobe, data sampled in the following cycle only
  task automatic reg_read(input logic [1:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic wait_lock(input logic val, input int bound);
    int i;
    i = 0;
    while (pll_locked !== val && i < bound) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk("pll_locked", {15'h0, val}, {15'h0, pll_locked});
  endtask

  // request a switch and wait for the current source to follow
  task automatic switch_src(input logic [2:0] s);
    int i;
    i = 0;
    reg_write(OFS_OSC_CONTROL, {5'h0, s, 7'h0, 1'b1});
    while (cur_source !== s && i < 10) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk("cur_source", {13'h0, s}, {13'h0, cur_source});
  endtask

  // cycles from one system tick to the next
  task automatic tick_gap(output int gap);
    int n;
    n = 0;
    while (sys_clk_tick !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (sys_clk_tick !== 1'b1 && n < 600);
    gap = n;
  endtask

  initial begin
    n_fail = 0; checked = 0; cycles = 0;
    reset_n = 1'b0; reg_addr = 2'h0; reg_wdata = 16'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    initial_source_code = 3'h7; rc_tick = 1'b1; prim_tick = 1'b1;
    startup_timer_done = 1'b0; pll_out_tick = 1'b1;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("cur_source", 16'h0007, {13'h0, cur_source});
    chk("n1", 16'h0002, {10'h0, pll_in_ratio});
    chk("m", 16'h0032, {6'h0, pll_fb_ratio});
    chk("n2", 16'h0004, {12'h0, pll_out_ratio});
    reg_read(OFS_CLOCK_DIVISOR, d);
    chk("clock_divisor", 16'h0040, d & 16'h07df);
    reg_read(OFS_PLL_FEEDBACK, d);
    chk("pll_feedback_divisor", 16'h0030, d & 16'h01ff);
    reg_read(OFS_OSC_CONTROL, d);
    chk("lock bit", 16'h0000, {15'h0, d[5]});
    reg_write(2'h3, 16'hffff);
    reg_read(2'h3, d);
    chk("unmapped", 16'h0000, d);
    // every postscaler code, measured on the system tick
    for (int c = 0; c < 8; c++) begin
      reg_write(OFS_CLOCK_DIVISOR, 16'h0040 | (16'(c) << 8));
      tick_gap(g);
      tick_gap(g);
      tick_gap(g);
      chk("rc period", (c == 7) ? 16'd256 : (16'h1 << c), 16'(g));
    end
    reg_write(OFS_CLOCK_DIVISOR, 16'h0140);
    tick_gap(g);
    tick_gap(g);
    tick_gap(g);
    sc = 0;
    ic = 0;
    repeat (64) begin
      @(posedge sys_clk);
      #1;
      sc += int'(sys_clk_tick);
      ic += int'(instr_tick);
    end
    chk("sys ticks", 16'd32, 16'(sc));
    chk("instr ticks", 16'd16, 16'(ic));
    // fixed divide-by-16 source ignores the software code
    switch_src(3'h6);
    tick_gap(g);
    tick_gap(g);
    tick_gap(g);
    chk("rc div16 period", 16'd16, 16'(g));
    // postscaler and defaults set while off the pll
    reg_write(OFS_CLOCK_DIVISOR, 16'h0040);
    // rc with multiplier: lock restarts on the switch
    switch_src(3'h1);
    chk("lock at switch", 16'h0000, {15'h0, pll_locked});
    wait_lock(1'b1, LOCK + 10);
    sc = 0;
    ic = 0;
    repeat (20) begin
      @(posedge sys_clk);
      #1;
      sc += int'(pll_ref_tick);
      ic += int'(sys_clk_tick);
    end
    chk("ref present", 16'h0001, {15'h0, sc > 0});
    chk("pll tick present", 16'h0001, {15'h0, ic > 0});
    reg_write(OFS_OSC_CONTROL, 16'h0100);
    reg_read(OFS_OSC_CONTROL, d);
    chk("lock bit", 16'h0001, {15'h0, d[5]});
    reg_write(OFS_CLOCK_DIVISOR, 16'h00df);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("n1 frozen", 16'h0002, {10'h0, pll_in_ratio});
    chk("n2 frozen", 16'h0004, {12'h0, pll_out_ratio});
    chk("lock after input divider", 16'h0000, {15'h0, pll_locked});
    wait_lock(1'b1, LOCK + 10);
    // a feedback value that really differs restarts the lock interval
    reg_write(OFS_PLL_FEEDBACK, 16'h0031);
    #1;
    chk("lock after feedback", 16'h0000, {15'h0, pll_locked});
    wait_lock(1'b1, LOCK + 10);
    // primary with multiplier waits for the start-up timer
    switch_src(3'h3);
    repeat (LOCK + 10) @(posedge sys_clk);
    #1;
    chk("lock before startup", 16'h0000, {15'h0, pll_locked});
    @(posedge sys_clk);
    startup_timer_done <= 1'b1;
    wait_lock(1'b1, LOCK + 10);
    // plain rc: lock held clear, new ratios take effect
    switch_src(3'h0);
    chk("lock off pll", 16'h0000, {15'h0, pll_locked});
    repeat (2) @(posedge sys_clk);
    #1;
    chk("n1", 16'h0021, {10'h0, pll_in_ratio});
    chk("n2", 16'h0008, {12'h0, pll_out_ratio});
    reg_write(OFS_PLL_FEEDBACK, 16'h01ff);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("m", 16'h0201, {6'h0, pll_fb_ratio});
    reg_read(OFS_PLL_FEEDBACK, d);
    chk("pll_feedback_divisor", 16'h01ff, d & 16'h01ff);
    repeat (LOCK + 10) @(posedge sys_clk);
    #1;
    chk("lock stays clear", 16'h0000, {15'h0, pll_locked});
    complete_run();
  end
endmodule  // fpd_top_bench
